// >>> hw/rtcal_pkg.sv
// Constants and carrier types for the alarm, square-wave and countdown block
package rtcal_pkg;
	localparam logic [3:0] ADDR_IRQ_CS     = 4'h1;
	localparam logic [3:0] ADDR_MIN_MATCH  = 4'h9;
	localparam logic [3:0] ADDR_HOUR_MATCH = 4'hA;
	localparam logic [3:0] ADDR_DAY_MATCH  = 4'hB;
	localparam logic [3:0] ADDR_WDAY_MATCH = 4'hC;
	localparam logic [3:0] ADDR_SQW_CTRL   = 4'hD;
	localparam logic [3:0] ADDR_CD_CTRL    = 4'hE;
	localparam logic [3:0] ADDR_CD_VALUE   = 4'hF;

	// Interrupt control/status bit positions, plus match disable and countdown run bits
	localparam int BIT_MINUTE_EV  = 7;
	localparam int BIT_SECOND_EV  = 6;
	localparam int BIT_TICK_FLAG  = 5;
	localparam int BIT_PULSE_MODE = 4;
	localparam int BIT_ALARM_FLAG = 3;
	localparam int BIT_CD_FLAG    = 2;
	localparam int BIT_ALARM_GATE = 1;
	localparam int BIT_CD_GATE    = 0;
	localparam int BIT_DISABLE    = 7;
	localparam int BIT_CD_RUN     = 7;

	// Reset values
	localparam logic [7:0] RST_IRQ_CS     = 8'h00;
	localparam logic [7:0] RST_MATCH      = 8'h80;
	localparam logic [2:0] RST_SQW_SEL    = 3'h0;
	localparam logic [1:0] RST_CD_SRC     = 2'h3;
	localparam logic [7:0] RST_CD_VALUE   = 8'h00;

	// Field masks of stored match values
	localparam logic [6:0] MASK_MIN  = 7'h7F;
	localparam logic [6:0] MASK_HOUR = 7'h3F;
	localparam logic [6:0] MASK_DAY  = 7'h3F;
	localparam logic [6:0] MASK_WDAY = 7'h07;

	// Timing
	localparam int CLK_PERIOD_NS   = 20;
	localparam int XTAL_DIV_BITS   = 15;
	localparam int SEC_PER_MINUTE  = 60;
	localparam int TICK_AUTOCLR_S  = 1;
	localparam logic [5:0] MINUTE_LAST   = 6'(SEC_PER_MINUTE - 1);
	localparam logic [1:0] AUTOCLR_COUNT = 2'(TICK_AUTOCLR_S);

	typedef enum logic [2:0] {
		RTCAL_SQ_32768 = 3'b000,
		RTCAL_SQ_16384 = 3'b001,
		RTCAL_SQ_8192  = 3'b010,
		RTCAL_SQ_4096  = 3'b011,
		RTCAL_SQ_2048  = 3'b100,
		RTCAL_SQ_1024  = 3'b101,
		RTCAL_SQ_1HZ   = 3'b110,
		RTCAL_SQ_LOW   = 3'b111
	} rtcal_sq_type;

	typedef enum logic [1:0] {
		RTCAL_CD_4096HZ = 2'b00,
		RTCAL_CD_64HZ   = 2'b01,
		RTCAL_CD_1HZ    = 2'b10,
		RTCAL_CD_60S    = 2'b11
	} rtcal_cd_type;

	typedef struct packed {
		logic [7:0] minute;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] weekday;
	} rtcal_time_type;
endpackage : rtcal_pkg

// >>> hw/rtcal_top.sv
// Alarm compare, square-wave divider, countdown and tick event logic
//
// Notes on behaviour
// - Day match: disable bit7, bit6 zero, BCD day.
// - Weekday match: disable bit7, bits6:3 zero, weekday.
// - Enabled matches all equal first: set alarm flag.
// - Disabled match registers take no part.
// - Alarm flag sticky; sets again only on new match.
// - Alarm gate set: interrupt follows alarm flag.
// - Flag writes AND with present value.
// - Flags: tick bit5, alarm bit3, countdown bit2.
// - Square-wave select codes, 111 low, default 000.
// - Square wave on at reset, low when off.
// - Divided outputs have equal high and low time.
// - Stop forces 4096 Hz and slower low.
// - Countdown control: run bit7, source bits1:0.
// - Countdown value full byte, period value/rate.
// - Tick interrupt per second or per minute.
// - Tick flag set on second or minute advance.
// - Minute-only mode: tick flag self-clears after 1s.
// - Tick pulses continue regardless of tick flag.
// - Minute match: disable bit7, BCD minute 6:0.
// - Hour match: disable bit7, bit6 zero, hour 5:0.
// - Interrupt pin active low, sources wired-OR.
// - Countdown at 1: flag, reload; value 0 stops.
`timescale 1ns/1ps
module rtcal_top (
	input  wire logic                    CLOCK,
	input  wire logic                    RST,
	input  wire logic                    CE,
	input  wire logic                    XTAL_LEVEL,
	input  wire logic                    SEC_ADVANCE,
	input  wire logic                    MIN_ADVANCE,
	input  wire logic                    CLOCK_STOP,
	input  wire rtcal_pkg::rtcal_time_type CUR_TIME,
	input  wire logic [3:0]              REG_ADDR,
	input  wire logic                    REG_WR,
	input  wire logic                    REG_RD,
	input  wire logic [7:0]              REG_WDATA,
	output logic      [7:0]              REG_RDATA,
	output logic                         IRQ_PIN_O,
	output logic                         IRQ_PIN_OE_N,
	output logic                         SQUARE_WAVE_PIN_O,
	output logic                         SQUARE_WAVE_PIN_OE_N
);
	logic [7:0]  ctl_r;
	logic        alarm_hit_flag_r;
	logic        tick_event_flag_r;
	logic        countdown_done_flag_r;
	logic [3:0]  match_disable_bits_r;
	logic [6:0]  min_match_r;
	logic [6:0]  hour_match_r;
	logic [6:0]  day_match_r;
	logic [6:0]  wday_match_r;
	logic [2:0]  square_wave_select_r;
	logic        countdown_run_r;
	logic [1:0]  countdown_source_select_r;
	logic [7:0]  cd_store_r;
	logic [7:0]  cd_count_r;
	logic [14:0] div_r;
	logic        xtal_d_r;
	logic [5:0]  minute_pre_r;
	logic        adv_d_r;
	logic        match_prev_r;
	logic [1:0]  autoclr_r;
	logic        tick_pulse_r;
	logic        cd_pulse_r;
	logic        sq_r;
	logic        irq_r;
	logic [7:0]  rdata_nxt;
	logic        xtal_rise;
	logic        tick_4096;
	logic        tick_64;
	logic        tick_1hz;
	logic        tick_60s;
	logic        cd_tick;
	logic        all_match;
	logic        any_enabled;
	logic        alarm_set;
	logic        tick_set;
	logic        cd_set;
	logic        sq_nxt;
	logic        irq_nxt;
	logic        wr_irq;
	logic [3:0]  field_eq;
	logic [6:0]  match_val  [4];
	logic [6:0]  match_cur  [4];
	logic [6:0]  match_mask [4];

	wire sixty_second_event_enable = ctl_r[rtcal_pkg::BIT_MINUTE_EV];
	wire one_second_event_enable   = ctl_r[rtcal_pkg::BIT_SECOND_EV];
	wire irq_pulse_mode            = ctl_r[rtcal_pkg::BIT_PULSE_MODE];
	wire alarm_irq_gate            = ctl_r[rtcal_pkg::BIT_ALARM_GATE];
	wire countdown_irq_gate        = ctl_r[rtcal_pkg::BIT_CD_GATE];

	assign wr_irq = REG_WR && (REG_ADDR == rtcal_pkg::ADDR_IRQ_CS);

	// Crystal edge and divider taps
	assign xtal_rise = XTAL_LEVEL && !xtal_d_r;
	assign tick_4096 = xtal_rise && (&div_r[2:0]);
	assign tick_64   = xtal_rise && (&div_r[8:0]);
	assign tick_1hz  = xtal_rise && (&div_r);
	assign tick_60s  = tick_1hz && (minute_pre_r == rtcal_pkg::MINUTE_LAST);

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			xtal_d_r <= 1'b0;
			div_r    <= 15'h0000;
		end else if (CE) begin
			xtal_d_r <= XTAL_LEVEL;
			if (xtal_rise) begin
				div_r <= div_r + 15'h0001;
			end
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			minute_pre_r <= 6'h00;
		end else if (CE && tick_1hz) begin
			minute_pre_r <= (minute_pre_r == rtcal_pkg::MINUTE_LAST) ? 6'h00 : minute_pre_r + 6'h01;
		end
	end

	// Control bits kept in the interrupt register
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ctl_r <= rtcal_pkg::RST_IRQ_CS;
		end else if (CE && wr_irq) begin
			ctl_r <= REG_WDATA & 8'hD3;
		end
	end

	// Match and control registers; unused bits never stored
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			match_disable_bits_r      <= 4'hF;
			min_match_r               <= rtcal_pkg::RST_MATCH[6:0] & rtcal_pkg::MASK_MIN;
			hour_match_r              <= 7'h00;
			day_match_r               <= 7'h00;
			wday_match_r              <= 7'h00;
			square_wave_select_r      <= rtcal_pkg::RST_SQW_SEL;
			countdown_run_r           <= 1'b0;
			countdown_source_select_r <= rtcal_pkg::RST_CD_SRC;
			cd_store_r                <= rtcal_pkg::RST_CD_VALUE;
		end else if (CE && REG_WR) begin
			case (REG_ADDR)
				rtcal_pkg::ADDR_MIN_MATCH: begin
					match_disable_bits_r[0] <= REG_WDATA[rtcal_pkg::BIT_DISABLE];
					min_match_r             <= REG_WDATA[6:0] & rtcal_pkg::MASK_MIN;
				end
				rtcal_pkg::ADDR_HOUR_MATCH: begin
					match_disable_bits_r[1] <= REG_WDATA[rtcal_pkg::BIT_DISABLE];
					hour_match_r            <= REG_WDATA[6:0] & rtcal_pkg::MASK_HOUR;
				end
				rtcal_pkg::ADDR_DAY_MATCH: begin
					match_disable_bits_r[2] <= REG_WDATA[rtcal_pkg::BIT_DISABLE];
					day_match_r             <= REG_WDATA[6:0] & rtcal_pkg::MASK_DAY;
				end
				rtcal_pkg::ADDR_WDAY_MATCH: begin
					match_disable_bits_r[3] <= REG_WDATA[rtcal_pkg::BIT_DISABLE];
					wday_match_r            <= REG_WDATA[6:0] & rtcal_pkg::MASK_WDAY;
				end
				rtcal_pkg::ADDR_SQW_CTRL: begin
					square_wave_select_r <= REG_WDATA[2:0];
				end
				rtcal_pkg::ADDR_CD_CTRL: begin
					countdown_run_r           <= REG_WDATA[rtcal_pkg::BIT_CD_RUN];
					countdown_source_select_r <= REG_WDATA[1:0];
				end
				rtcal_pkg::ADDR_CD_VALUE: begin
					cd_store_r <= REG_WDATA;
				end
				default: begin
				end
			endcase
		end
	end

	// Alarm comparison, one field per generate entry
	assign match_val[0]  = min_match_r;
	assign match_val[1]  = hour_match_r;
	assign match_val[2]  = day_match_r;
	assign match_val[3]  = wday_match_r;
	assign match_cur[0]  = CUR_TIME.minute[6:0];
	assign match_cur[1]  = CUR_TIME.hour[6:0];
	assign match_cur[2]  = CUR_TIME.day[6:0];
	assign match_cur[3]  = CUR_TIME.weekday[6:0];
	assign match_mask[0] = rtcal_pkg::MASK_MIN;
	assign match_mask[1] = rtcal_pkg::MASK_HOUR;
	assign match_mask[2] = rtcal_pkg::MASK_DAY;
	assign match_mask[3] = rtcal_pkg::MASK_WDAY;

	for (genvar g = 0; g < 4; g++) begin : g_field
		assign field_eq[g] = match_disable_bits_r[g] ||
			((match_cur[g] & match_mask[g]) == match_val[g]);
	end

	assign all_match   = &field_eq;
	assign any_enabled = !(&match_disable_bits_r);
	// Evaluated one cycle after the counters advance, on entry into a match
	assign alarm_set   = adv_d_r && all_match && any_enabled && !match_prev_r;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			adv_d_r      <= 1'b0;
			match_prev_r <= 1'b0;
		end else if (CE) begin
			adv_d_r <= MIN_ADVANCE;
			if (adv_d_r) begin
				match_prev_r <= all_match && any_enabled;
			end
		end
	end

	// Tick events
	assign tick_set = one_second_event_enable ? SEC_ADVANCE :
		(sixty_second_event_enable && MIN_ADVANCE);

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			autoclr_r <= 2'h0;
		end else if (CE) begin
			if (tick_set && !one_second_event_enable) begin
				autoclr_r <= rtcal_pkg::AUTOCLR_COUNT;
			end else if (SEC_ADVANCE && autoclr_r != 2'h0) begin
				autoclr_r <= autoclr_r - 2'h1;
			end
		end
	end

	// Countdown
	always_comb begin
		case (rtcal_pkg::rtcal_cd_type'(countdown_source_select_r))
			rtcal_pkg::RTCAL_CD_4096HZ: cd_tick = tick_4096;
			rtcal_pkg::RTCAL_CD_64HZ:   cd_tick = tick_64;
			rtcal_pkg::RTCAL_CD_1HZ:    cd_tick = tick_1hz;
			rtcal_pkg::RTCAL_CD_60S:    cd_tick = tick_60s;
			default:                    cd_tick = 1'b0;
		endcase
	end

	assign cd_set = countdown_run_r && cd_tick && (cd_count_r == 8'h01);

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			cd_count_r <= rtcal_pkg::RST_CD_VALUE;
		end else if (CE) begin
			if (REG_WR && REG_ADDR == rtcal_pkg::ADDR_CD_VALUE) begin
				cd_count_r <= REG_WDATA;
			end else if (countdown_run_r && cd_tick && cd_count_r != 8'h00) begin
				cd_count_r <= (cd_count_r == 8'h01) ? cd_store_r : cd_count_r - 8'h01;
			end
		end
	end

	// Flags: hardware set wins over a same-cycle clear
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			alarm_hit_flag_r      <= 1'b0;
			tick_event_flag_r     <= 1'b0;
			countdown_done_flag_r <= 1'b0;
		end else if (CE) begin
			alarm_hit_flag_r <= alarm_set ||
				(alarm_hit_flag_r && !(wr_irq && !REG_WDATA[rtcal_pkg::BIT_ALARM_FLAG]));
			countdown_done_flag_r <= cd_set ||
				(countdown_done_flag_r && !(wr_irq && !REG_WDATA[rtcal_pkg::BIT_CD_FLAG]));
			tick_event_flag_r <= tick_set ||
				(tick_event_flag_r && !(wr_irq && !REG_WDATA[rtcal_pkg::BIT_TICK_FLAG]) &&
				 !(SEC_ADVANCE && autoclr_r == 2'h1));
		end
	end

	// Interrupt pulses, ended by the next 64 Hz tick
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			tick_pulse_r <= 1'b0;
			cd_pulse_r   <= 1'b0;
		end else if (CE) begin
			if (tick_set) begin
				tick_pulse_r <= 1'b1;
			end else if (tick_64) begin
				tick_pulse_r <= 1'b0;
			end
			if (cd_set) begin
				cd_pulse_r <= 1'b1;
			end else if (tick_64) begin
				cd_pulse_r <= 1'b0;
			end
		end
	end

	always_comb begin
		irq_nxt = (alarm_irq_gate && alarm_hit_flag_r) ||
			(countdown_irq_gate && (irq_pulse_mode ? cd_pulse_r : countdown_done_flag_r)) ||
			(irq_pulse_mode ? tick_pulse_r : tick_event_flag_r);
	end

	// Square-wave tap selection
	always_comb begin
		case (rtcal_pkg::rtcal_sq_type'(square_wave_select_r))
			rtcal_pkg::RTCAL_SQ_32768: sq_nxt = XTAL_LEVEL;
			rtcal_pkg::RTCAL_SQ_16384: sq_nxt = div_r[0];
			rtcal_pkg::RTCAL_SQ_8192:  sq_nxt = div_r[1];
			rtcal_pkg::RTCAL_SQ_4096:  sq_nxt = div_r[2] && !CLOCK_STOP;
			rtcal_pkg::RTCAL_SQ_2048:  sq_nxt = div_r[3] && !CLOCK_STOP;
			rtcal_pkg::RTCAL_SQ_1024:  sq_nxt = div_r[4] && !CLOCK_STOP;
			rtcal_pkg::RTCAL_SQ_1HZ:   sq_nxt = div_r[14] && !CLOCK_STOP;
			rtcal_pkg::RTCAL_SQ_LOW:   sq_nxt = 1'b0;
			default:                   sq_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sq_r  <= 1'b0;
			irq_r <= 1'b0;
		end else if (CE) begin
			sq_r  <= sq_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Open drain pins: enable low pulls the wire low
	assign SQUARE_WAVE_PIN_O    = 1'b0;
	assign SQUARE_WAVE_PIN_OE_N = sq_r;
	assign IRQ_PIN_O            = 1'b0;
	assign IRQ_PIN_OE_N         = !irq_r;

	// Register read-back
	always_comb begin
		case (REG_ADDR)
			rtcal_pkg::ADDR_IRQ_CS: begin
				rdata_nxt = ctl_r;
				rdata_nxt[rtcal_pkg::BIT_TICK_FLAG]  = tick_event_flag_r;
				rdata_nxt[rtcal_pkg::BIT_ALARM_FLAG] = alarm_hit_flag_r;
				rdata_nxt[rtcal_pkg::BIT_CD_FLAG]    = countdown_done_flag_r;
			end
			rtcal_pkg::ADDR_MIN_MATCH:  rdata_nxt = {match_disable_bits_r[0], min_match_r};
			rtcal_pkg::ADDR_HOUR_MATCH: rdata_nxt = {match_disable_bits_r[1], hour_match_r};
			rtcal_pkg::ADDR_DAY_MATCH:  rdata_nxt = {match_disable_bits_r[2], day_match_r};
			rtcal_pkg::ADDR_WDAY_MATCH: rdata_nxt = {match_disable_bits_r[3], wday_match_r};
			rtcal_pkg::ADDR_SQW_CTRL:   rdata_nxt = {5'h00, square_wave_select_r};
			rtcal_pkg::ADDR_CD_CTRL:    rdata_nxt = {countdown_run_r, 5'h00, countdown_source_select_r};
			rtcal_pkg::ADDR_CD_VALUE:   rdata_nxt = cd_count_r;
			default:                    rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			REG_RDATA <= 8'h00;
		end else if (CE && REG_RD) begin
			REG_RDATA <= rdata_nxt;
		end
	end
endmodule : rtcal_top

// >>> dv/rtcal_assertions.sv
// Port-level concurrent checks for the alarm, square-wave and countdown block
`timescale 1ns/1ps
module rtcal_assertions (
	input wire logic       CLOCK,
	input wire logic       RST,
	input wire logic       CE,
	input wire logic       XTAL_LEVEL,
	input wire logic       CLOCK_STOP,
	input wire logic [3:0] REG_ADDR,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic       IRQ_PIN_O,
	input wire logic       IRQ_PIN_OE_N,
	input wire logic       SQUARE_WAVE_PIN_O,
	input wire logic       SQUARE_WAVE_PIN_OE_N
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	logic [2:0] sel_r;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sel_r <= 3'h0;
		end else if (CE && REG_WR && REG_ADDR == rtcal_pkg::ADDR_SQW_CTRL) begin
			sel_r <= REG_WDATA[2:0];
		end
	end
	function automatic logic [7:0] unused_bits(input logic [3:0] a);
		case (a)
			4'hA, 4'hB: return 8'h40;
			4'hC: return 8'h78;
			4'hD: return 8'hF8;
			4'hE: return 8'h7C;
			default: return 8'h00;
		endcase
	endfunction : unused_bits
	a_sqw_follow_xtal: assert property (
		!$past(RST) && $past(CE) && sel_r == 3'h0 && $past(sel_r) == 3'h0
		|-> SQUARE_WAVE_PIN_OE_N == $past(XTAL_LEVEL)) else $error("square wave not following crystal");
	a_sqw_off_low: assert property (
		sel_r == 3'h7 && $past(sel_r) == 3'h7 |-> !SQUARE_WAVE_PIN_OE_N) else $error("square wave not low");
	a_stop_forces_low: assert property (
		CLOCK_STOP && $past(CLOCK_STOP) && sel_r inside {[3'h3:3'h6]} && $past(sel_r) inside {[3'h3:3'h6]}
		|-> !SQUARE_WAVE_PIN_OE_N) else $error("stopped square wave not low");
	a_pins_open_drain: assert property (
		!IRQ_PIN_O && !SQUARE_WAVE_PIN_O) else $error("open-drain pin driven high");
	a_rd_unmapped: assert property (
		$past(REG_RD && CE) && ($past(REG_ADDR) == 4'h0 || $past(REG_ADDR) inside {[4'h2:4'h8]})
		|-> REG_RDATA == 8'h00) else $error("unmapped read not zero");
	a_rd_unused_zero: assert property (
		$past(REG_RD && CE) |-> (REG_RDATA & unused_bits($past(REG_ADDR))) == 8'h00)
		else $error("unused bits read nonzero");
	a_irq_from_flags: assert property (
		$past(REG_RD && CE) && $past(REG_ADDR) == rtcal_pkg::ADDR_IRQ_CS
		&& ((REG_RDATA[1] && REG_RDATA[3]) || (REG_RDATA[5] && !REG_RDATA[4]))
		|-> ##[0:2] !IRQ_PIN_OE_N) else $error("interrupt not asserted for set flag");
	a_reset_levels: assert property (@(posedge CLOCK) disable iff (1'b0)
		RST && $past(RST) |-> IRQ_PIN_OE_N && !SQUARE_WAVE_PIN_OE_N && REG_RDATA == 8'h00)
		else $error("wrong levels in reset");
	c_irq_active: cover property (!IRQ_PIN_OE_N);
	c_stop_low: cover property (CLOCK_STOP && sel_r == 3'h3);
	c_sqw_off: cover property (sel_r == 3'h7 && $past(sel_r) == 3'h7);
endmodule : rtcal_assertions

bind rtcal_top rtcal_assertions u_chk (.CLOCK(CLOCK), .RST(RST), .CE(CE), .XTAL_LEVEL(XTAL_LEVEL),
	.CLOCK_STOP(CLOCK_STOP), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
	.REG_RDATA(REG_RDATA), .IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE_N(IRQ_PIN_OE_N),
	.SQUARE_WAVE_PIN_O(SQUARE_WAVE_PIN_O), .SQUARE_WAVE_PIN_OE_N(SQUARE_WAVE_PIN_OE_N));

// >>> dv/rtcal_host_model.sv
// Host controller model on the register strobe port
`timescale 1ns/1ps
module rtcal_host_model (
	input  wire logic       clock,
	output logic [3:0]      addr,
	output logic            wr,
	output logic            rd,
	output logic [7:0]      wdata,
	input  wire logic [7:0] rdata
);
	initial begin
		addr = 4'h0;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'h00;
	end
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		wdata <= ~d;
	endtask : wreg
	task automatic rreg(input logic [3:0] a, output logic [7:0] q);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		q = rdata;
	endtask : rreg
	// Clears chosen flags, writes 1 to the others and writes control bits from ctl
	task automatic clr(input logic [7:0] ctl, input logic [7:0] flags);
		wreg(4'h1, (ctl & 8'hD3) | (~flags & 8'h2C));
	endtask : clr
endmodule : rtcal_host_model

// >>> dv/tb.sv
// Self-checking bench for the alarm, square-wave and countdown block
`timescale 1ns/1ps
module tb;
	logic                     clock, rst, ce, xtal, sec_adv, min_adv, stop, wr, rd, irq_o, irq_oe_n, sq_o, sq_oe_n;
	logic [3:0]               addr;
	logic [7:0]               wdata, rdata, q, wd;
	logic [2:0]               xcnt;
	rtcal_pkg::rtcal_time_type cur_time;
	int                       n_fail = 0, compares = 0, hi, lo, n;
	wire                      irq_n = irq_oe_n ? 1'b1 : irq_o;
	wire                      sqw_lvl = sq_oe_n ? 1'b1 : sq_o;
	rtcal_top u_dut (.CLOCK(clock), .RST(rst), .CE(ce), .XTAL_LEVEL(xtal), .SEC_ADVANCE(sec_adv),
		.MIN_ADVANCE(min_adv), .CLOCK_STOP(stop), .CUR_TIME(cur_time), .REG_ADDR(addr), .REG_WR(wr),
		.REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .IRQ_PIN_O(irq_o), .IRQ_PIN_OE_N(irq_oe_n),
		.SQUARE_WAVE_PIN_O(sq_o), .SQUARE_WAVE_PIN_OE_N(sq_oe_n));
	rtcal_host_model u_host (.clock(clock), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Crystal stand-in: 16 system cycles per period
	always @(posedge clock) begin
		xcnt <= xcnt + 3'h1;
		if (xcnt == 3'h7) xtal <= ~xtal;
	end
	function automatic logic [7:0] rd_mask(input logic [3:0] a);
		case (a)
			4'h9, 4'hF: return 8'hFF;
			4'hA, 4'hB: return 8'hBF;
			4'hC: return 8'h87;
			4'hD: return 8'h07;
			4'hE: return 8'h83;
			default: return 8'h00;
		endcase
	endfunction : rd_mask
	function automatic logic [7:0] rst_val(input logic [3:0] a);
		return (a inside {[4'h9:4'hC]}) ? 8'h80 : (a == 4'hE) ? 8'h03 : 8'h00;
	endfunction : rst_val
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic adv(input logic is_min, input logic [7:0] m);
		@(posedge clock);
		cur_time <= {m, 8'($urandom), 8'($urandom), 8'($urandom)};
		sec_adv <= ~is_min;
		min_adv <= is_min;
		@(posedge clock);
		sec_adv <= 1'b0;
		min_adv <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask : adv
	// Pin level is looked at 1 ns after each edge, once it has settled
	task automatic meas();
		n = 0;
		while (sqw_lvl !== 1'b0 && n < 1200) begin
			@(posedge clock);
			#1;
			n++;
		end
		while (sqw_lvl !== 1'b1 && n < 1200) begin
			@(posedge clock);
			#1;
			n++;
		end
		hi = 0;
		lo = 0;
		while (sqw_lvl === 1'b1 && hi < 600) begin
			@(posedge clock);
			#1;
			hi++;
		end
		while (sqw_lvl === 1'b0 && lo < 600) begin
			@(posedge clock);
			#1;
			lo++;
		end
	endtask : meas
	task automatic high_count();
		hi = 0;
		repeat (4) @(posedge clock);
		repeat (300) begin
			@(posedge clock);
			#1;
			hi += (sqw_lvl !== 1'b0);
		end
	endtask : high_count
	task automatic wrap_up();
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (60000) @(posedge clock);
		n_fail++;
		$display("watchdog expired");
		wrap_up();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		xtal = 1'b0;
		xcnt = 3'h0;
		sec_adv = 1'b0;
		min_adv = 1'b0;
		stop = 1'b0;
		cur_time = '0;
		void'($urandom(16));
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		for (int a = 1; a < 16; a++) begin
			u_host.rreg(4'(a), q);
			if (a == 1 || a > 8) chk("reset_value", rst_val(4'(a)), q);
		end
		for (int r = 0; r < 3; r++) begin
			for (int a = 2; a < 16; a++) begin
				wd = (r == 0) ? 8'hFF : 8'($urandom);
				// Countdown left stopped so the live value read back cannot move
				if (r > 0 && a == 14) wd[7] = 1'b0;
				u_host.wreg(4'(a), wd);
				u_host.rreg(4'(a), q);
				chk("reg_rw", wd & rd_mask(4'(a)), q);
			end
		end
		$display("test registers done");
		u_host.wreg(4'hF, 8'h00);
		u_host.wreg(4'hE, 8'h03);
		u_host.wreg(4'h1, 8'h00);
		for (int a = 9; a < 13; a++) u_host.wreg(4'(a), 8'h80);
		u_host.wreg(4'h9, 8'h15);
		u_host.wreg(4'h1, 8'h02);
		adv(1'b1, 8'h14);
		u_host.rreg(4'h1, q);
		chk("alarm_miss", 8'h02, q);
		adv(1'b1, 8'h15);
		u_host.rreg(4'h1, q);
		chk("alarm_hit", 8'h0A, q);
		chk("irq_alarm", 8'h00, {7'h0, irq_n});
		u_host.clr(8'h02, 8'h08);
		u_host.rreg(4'h1, q);
		chk("alarm_clear", 8'h02, q);
		chk("irq_idle", 8'h01, {7'h0, irq_n});
		adv(1'b1, 8'h15);
		u_host.rreg(4'h1, q);
		chk("alarm_same", 8'h02, q);
		adv(1'b1, 8'h16);
		adv(1'b1, 8'h15);
		u_host.rreg(4'h1, q);
		chk("alarm_again", 8'h0A, q);
		u_host.clr(8'h00, 8'h00);
		u_host.rreg(4'h1, q);
		chk("alarm_kept", 8'h08, q);
		chk("irq_gated", 8'h01, {7'h0, irq_n});
		u_host.wreg(4'h1, 8'h00);
		u_host.wreg(4'h9, 8'h80);
		$display("test alarm done");
		u_host.wreg(4'h1, 8'h40);
		adv(1'b0, 8'h00);
		u_host.rreg(4'h1, q);
		chk("tick_sec", 8'h60, q);
		chk("irq_tick", 8'h00, {7'h0, irq_n});
		u_host.clr(8'h40, 8'h20);
		u_host.clr(8'h80, 8'h00);
		adv(1'b0, 8'h00);
		u_host.rreg(4'h1, q);
		chk("tick_min_sec", 8'h80, q);
		adv(1'b1, 8'h01);
		u_host.rreg(4'h1, q);
		chk("tick_min", 8'hA0, q);
		adv(1'b0, 8'h01);
		u_host.rreg(4'h1, q);
		chk("tick_auto_clear", 8'h80, q);
		u_host.wreg(4'h1, 8'h00);
		adv(1'b0, 8'h02);
		adv(1'b1, 8'h02);
		u_host.rreg(4'h1, q);
		chk("tick_off", 8'h00, q);
		u_host.wreg(4'h1, 8'h50);
		adv(1'b0, 8'h02);
		chk("pulse_first", 8'h00, {7'h0, irq_n});
		n = 0;
		while (irq_n !== 1'b1 && n < 9000) begin
			@(posedge clock);
			n++;
		end
		adv(1'b0, 8'h02);
		chk("pulse_again", 8'h00, {7'h0, irq_n});
		u_host.wreg(4'h1, 8'h01);
		$display("test tick done");
		u_host.wreg(4'hF, 8'h03);
		u_host.wreg(4'hE, 8'h80);
		repeat (600) @(posedge clock);
		u_host.rreg(4'h1, q);
		chk("cd_flag", 8'h05, q);
		u_host.rreg(4'hF, q);
		chk("cd_live", 8'h01, {7'h0, q inside {[8'h01:8'h03]}});
		u_host.wreg(4'hF, 8'h00);
		u_host.wreg(4'h1, 8'h01);
		repeat (600) @(posedge clock);
		u_host.rreg(4'h1, q);
		chk("cd_stopped", 8'h01, q);
		u_host.wreg(4'hE, 8'h03);
		// Clock enable low: the write strobe must be ignored
		@(posedge clock);
		ce <= 1'b0;
		u_host.wreg(4'hF, 8'h5A);
		ce <= 1'b1;
		u_host.rreg(4'hF, q);
		chk("ce_frozen", 8'h00, q);
		$display("test countdown done");
		for (int s = 1; s < 6; s++) begin
			u_host.wreg(4'hD, 8'(s));
			meas();
			chk("sqw_high", 8'h00, 8'(hi - (8 << s)));
			chk("sqw_low", 8'h00, 8'(lo - (8 << s)));
		end
		@(posedge clock);
		stop <= 1'b1;
		for (int s = 3; s < 7; s++) begin
			u_host.wreg(4'hD, 8'(s));
			high_count();
			chk("sqw_stopped", 8'h00, 8'(hi));
		end
		u_host.wreg(4'hD, 8'h02);
		meas();
		chk("sqw_stop_runs", 8'h20, 8'(hi));
		@(posedge clock);
		stop <= 1'b0;
		u_host.wreg(4'hD, 8'h07);
		high_count();
		chk("sqw_off", 8'h00, 8'(hi));
		$display("test square wave done");
		wrap_up();
	end
endmodule : tb
